// *** rtl/vrc_pkg.sv ***
/*
 * Shared constants, enumerations and carriers of the volts-per-hertz
 * profile and restart supervisor. Assumes a single 100 MHz clock.
 */
package vrc_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam logic [31:0] CLK_HZ     = 32'h05F5_E100;
	localparam logic [31:0] MS_PER_S   = 32'h0000_03E8;
	localparam logic [31:0] MS_PER_MIN = 32'h0000_EA60;
	localparam logic [31:0] TICK_CYC   = CLK_HZ / MS_PER_S;
	localparam logic [31:0] POWERUP_S  = 32'h2;
	localparam logic [31:0] BRAKE_S    = 32'hF;
	localparam logic [31:0] LOWF_MIN   = 32'h4;
	localparam logic [31:0] DECAY_MIN  = 32'hF;
	localparam logic [31:0] POWERUP_MS = POWERUP_S * MS_PER_S;
	localparam logic [31:0] BRAKE_MS   = BRAKE_S * MS_PER_S;
	localparam logic [31:0] LOWF_MS    = LOWF_MIN * MS_PER_MIN;
	localparam logic [31:0] DECAY_MS   = DECAY_MIN * MS_PER_MIN;

	// ---------------------------------------------------------------
	// Profile and carrier figures
	// ---------------------------------------------------------------
	localparam logic [2:0]  MAX_ATTEMPTS = 3'h5;
	localparam logic [13:0] V_FULL       = 14'h2710;
	localparam logic [31:0] TAPER_DIV    = 32'h2;
	localparam logic [31:0] FREQ_SCALE   = 32'hA;
	localparam logic [31:0] VC_MULT      = 32'h3C;
	localparam logic [15:0] LOWF_OUT     = 16'h000F;
	localparam logic [15:0] VC_KNEE      = 16'h00FA;
	localparam logic [15:0] VC_FIXED_HZ  = 16'h05DC;
	localparam logic [15:0] HI_OPT_LIM   = 16'h04B0;
	localparam logic [15:0] CAR_6K_HZ    = 16'h1770;
	localparam logic [15:0] CAR_8K_HZ    = 16'h1F40;
	localparam logic [15:0] CAR_10K_HZ   = 16'h2710;
	localparam logic [15:0] CAR_12K_HZ   = 16'h2EE0;
	localparam logic [15:0] CAR_14K_HZ   = 16'h36B0;
	localparam logic [2:0]  CAR_CODES    = 3'h6;

	typedef enum logic [1:0] {CURVE_CONST, CURVE_VAR, CURVE_CT_FLAT} vrc_curve_e;
	typedef enum logic [2:0] {CAR_2K5, CAR_6K, CAR_8K, CAR_10K, CAR_12K,
		CAR_14K} vrc_carrier_e;
	typedef enum logic [1:0] {MODE_NORMAL, MODE_POWER_ON,
		MODE_AUTO_RESTART, MODE_BRAKE_RESTART} vrc_mode_e;
	typedef enum logic [1:0] {FLT_PROTECT, FLT_CONTROL, FLT_SUPPLY_DIP,
		FLT_OUTPUT} vrc_fault_e;
	typedef enum logic [2:0] {ST_PWRUP, ST_IDLE, ST_RUN, ST_BRAKE, ST_DELAY,
		ST_LOCK} vrc_state_e;

	localparam vrc_carrier_e CARRIER_RST = CAR_8K;

	typedef struct packed {
		logic [15:0] base_freq;
		logic [13:0] fixed_low_speed_boost;
		logic        use_default_boost;
		logic [13:0] accel_voltage_boost;
		logic [13:0] load_speed_correction;
		vrc_curve_e  curve;
		logic [15:0] top_output_frequency_limit;
		logic        high_freq_option;
	} vrc_profile_s;

	typedef struct packed {
		logic       valid;
		vrc_fault_e kind;
	} vrc_fault_s;

	typedef struct packed {
		logic [13:0] output_voltage;
		logic [15:0] output_frequency;
		logic [15:0] carrier_hz;
		logic        carrier_menu_visible;
		logic        overload_speed_independent;
	} vrc_drive_s;

	typedef struct packed {
		vrc_state_e   state;
		logic [16:0]  pre;
		logic         tick;
		logic [19:0]  tmr;
		logic [19:0]  decay;
		logic [2:0]   attempts;
		logic         lowf_retry;
		logic         sync1;
		logic         sync2;
		logic         sync3;
		vrc_carrier_e car_sel;
		logic         car_rej;
		logic [7:0]   dc_lvl;
		vrc_drive_s   drv;
	} vrc_core_s;

endpackage

// *** rtl/vrc_boost_rom.sv ***
/*
 * Default fixed low-speed boost by power rating and supply class.
 * Assumes the index is stable logic on the same clock; output registered.
 */
`timescale 1ns/1ns
`default_nettype none

module vrc_boost_rom #(
	parameter int ENTRIES = 17
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [4:0]  rating_index,
	input  wire logic        supply_class_high,
	output logic      [13:0] boost_default
);

	// ---------------------------------------------------------------
	// Table, 0.01 % units; zero where a rating is not offered
	// ---------------------------------------------------------------
	localparam logic [9:0] LOW_V [ENTRIES] = '{10'h212, 10'h1B8, 10'h168,
		10'h12C, 10'h10E, 10'h0F0, 10'h0DC, 10'h0C8, 10'h0B4, 10'h0A0,
		10'h0E6, 10'h000, 10'h0D2, 10'h000, 10'h000, 10'h000, 10'h000};
	localparam logic [9:0] HIGH_V [ENTRIES] = '{10'h212, 10'h1B8, 10'h168,
		10'h12C, 10'h10E, 10'h0F0, 10'h0DC, 10'h0C8, 10'h0B4, 10'h0A0,
		10'h078, 10'h050, 10'h050, 10'h0C8, 10'h0BE, 10'h0BE, 10'h0B4};

	logic [13:0] next_boost_default;

	always_comb begin
		next_boost_default = '0;
		if (32'(rating_index) < ENTRIES) begin
			if (supply_class_high) begin
				next_boost_default = 14'(HIGH_V[rating_index]);
			end else begin
				next_boost_default = 14'(LOW_V[rating_index]);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			boost_default <= '0;
		end else begin
			boost_default <= next_boost_default;
		end
	end

endmodule

`default_nettype wire

// *** rtl/vrc_core.sv ***
/*
 * Volts-per-hertz profile, carrier choice and start/restart supervisor.
 * Assumes a ramp generator outside supplies commanded frequency, a
 * current measurement on the same clock, and an asynchronous start pin.
 */
// Functional notes
// - Voltage rises in proportion to frequency up to the base frequency on the constant curves.
// - Above rated-voltage frequency the voltage stays at full.
// - Fixed boost adds its value at zero Hz, fading to zero at half base.
// - Default fixed boost comes from a rating and supply class table.
// - Acceleration boost adds only while running below the set point.
// - Slip correction raises frequency with current times setting.
// - Curves: constant, variable (squared), constant with flat overload.
// - Flat overload curve selects speed-independent overload protection.
// - Carrier setting accepts only the six listed codes.
// - Variable carrier: 1.5 kHz to 25 Hz, then sixty times frequency.
// - High frequency option above 120 Hz forces 14 kHz, hides menu.
// - Power-on mode starts at power-up if start is held.
// - Auto restart mode restarts after faults and power-up if start held.
// - Brake-restart mode injects DC fifteen seconds before restarting.
// - Automatic start modes act only under terminal-strip control.
// - At most five restart attempts, then restart lockout.
// - Attempt counter drops by one every fifteen minutes.
// - Never restart after control or supply dip faults.
// - Output fault below 1.5 Hz: one retry after four minutes, then lock.
`timescale 1ns/1ns
`default_nettype none

module vrc_core #(
	parameter logic [16:0] TICK_CYCLES   = 17'(vrc_pkg::TICK_CYC),
	parameter logic [19:0] POWERUP_TICKS = 20'(vrc_pkg::POWERUP_MS),
	parameter logic [19:0] BRAKE_TICKS   = 20'(vrc_pkg::BRAKE_MS),
	parameter logic [19:0] LOWF_TICKS    = 20'(vrc_pkg::LOWF_MS),
	parameter logic [19:0] DECAY_TICKS   = 20'(vrc_pkg::DECAY_MS)
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire vrc_pkg::vrc_profile_s cfg,
	input  wire logic [4:0]           rating_index,
	input  wire logic                 supply_class_high,
	input  wire logic [2:0]           carrier_code,
	input  wire logic                 carrier_write,
	input  wire logic [15:0]          cmd_freq,
	input  wire logic [15:0]          set_point,
	input  wire logic [13:0]          motor_current,
	input  wire vrc_pkg::vrc_mode_e    start_mode,
	input  wire logic                 terminal_control,
	input  wire logic                 start_pin,
	input  wire logic                 keypad_start,
	input  wire logic                 keypad_stop,
	input  wire vrc_pkg::vrc_fault_s   fault,
	input  wire logic                 manual_reset,
	input  wire logic [7:0]           dc_injection_level,
	output var vrc_pkg::vrc_drive_s    drive,
	output logic                      carrier_rejected,
	output logic                      run_enable,
	output logic                      dc_injection_active,
	output logic [7:0]                dc_level_out,
	output logic                      restart_exhausted_lock,
	output logic [2:0]                restart_attempts
);

	vrc_pkg::vrc_core_s st;
	vrc_pkg::vrc_core_s next_st;
	logic [13:0] boost_dflt;
	logic [13:0] eff_boost;
	logic [31:0] fr;
	logic [31:0] bs;
	logic [31:0] ratio;
	logic [31:0] base_v;
	logic [31:0] taper;
	logic [31:0] fix_add;
	logic [31:0] acc_add;
	logic [31:0] vsum;
	logic [31:0] slip_add;
	logic [31:0] fsum;
	logic [31:0] lim;
	logic [31:0] vc;
	logic        forced;
	logic        tmr_done;
	logic        start_req;
	logic        stop_req;
	logic        auto_ok;
	logic        inc;
	logic        dec;

	vrc_boost_rom u_rom (
		.clk               (clk),
		.rst_n             (rst_n),
		.rating_index      (rating_index),
		.supply_class_high (supply_class_high),
		.boost_default     (boost_dflt)
	);

	assign eff_boost = cfg.use_default_boost ? boost_dflt
		: cfg.fixed_low_speed_boost;

	always_comb begin
		next_st = st;
		next_st.sync1 = start_pin;
		next_st.sync2 = st.sync1;
		next_st.sync3 = st.sync2;
		next_st.tick = 1'b0;
		if (st.pre == TICK_CYCLES - 17'h00001) begin
			next_st.pre = '0;
			next_st.tick = 1'b1;
		end else begin
			next_st.pre = st.pre + 17'h00001;
		end

		// -----------------------------------------------------------
		// Voltage profile
		// -----------------------------------------------------------
		fr = 32'(cmd_freq);
		bs = 32'(cfg.base_freq);
		if (bs == '0 || fr >= bs) begin
			ratio = 32'(vrc_pkg::V_FULL);
		end else begin
			ratio = fr * 32'(vrc_pkg::V_FULL) / bs;
		end
		unique case (cfg.curve)
			vrc_pkg::CURVE_VAR: base_v = ratio * ratio
				/ 32'(vrc_pkg::V_FULL);
			default: base_v = ratio;
		endcase
		taper = bs / vrc_pkg::TAPER_DIV;
		if (fr < taper) begin
			fix_add = 32'(eff_boost) * (taper - fr) / taper;
		end else begin
			fix_add = '0;
		end
		if (st.state == vrc_pkg::ST_RUN && cmd_freq < set_point) begin
			acc_add = 32'(cfg.accel_voltage_boost);
		end else begin
			acc_add = '0;
		end
		vsum = base_v + fix_add + acc_add;
		if (vsum > 32'(vrc_pkg::V_FULL)) begin
			next_st.drv.output_voltage = vrc_pkg::V_FULL;
		end else begin
			next_st.drv.output_voltage = vsum[13:0];
		end

		slip_add = bs * 32'(cfg.load_speed_correction)
			/ 32'(vrc_pkg::V_FULL) * 32'(motor_current)
			/ 32'(vrc_pkg::V_FULL);
		fsum = fr + slip_add;
		lim = 32'(cfg.top_output_frequency_limit);
		next_st.drv.output_frequency = (fsum > lim) ? lim[15:0] : fsum[15:0];
		next_st.drv.overload_speed_independent =
			(cfg.curve == vrc_pkg::CURVE_CT_FLAT);

		// -----------------------------------------------------------
		// Carrier
		// -----------------------------------------------------------
		next_st.car_rej = 1'b0;
		if (carrier_write) begin
			if (carrier_code < vrc_pkg::CAR_CODES) begin
				next_st.car_sel = vrc_pkg::vrc_carrier_e'(carrier_code);
			end else begin
				next_st.car_rej = 1'b1;
			end
		end
		forced = cfg.high_freq_option
			&& cfg.top_output_frequency_limit > vrc_pkg::HI_OPT_LIM;
		next_st.drv.carrier_menu_visible = !forced;
		vc = 32'(st.drv.output_frequency) * vrc_pkg::VC_MULT
			/ vrc_pkg::FREQ_SCALE;
		if (forced) begin
			next_st.drv.carrier_hz = vrc_pkg::CAR_14K_HZ;
		end else begin
			unique case (st.car_sel)
				vrc_pkg::CAR_2K5: begin
					if (st.drv.output_frequency <= vrc_pkg::VC_KNEE) begin
						next_st.drv.carrier_hz = vrc_pkg::VC_FIXED_HZ;
					end else if (vc > 32'h0000_FFFF) begin
						next_st.drv.carrier_hz = 16'hFFFF;
					end else begin
						next_st.drv.carrier_hz = vc[15:0];
					end
				end
				vrc_pkg::CAR_6K: next_st.drv.carrier_hz = vrc_pkg::CAR_6K_HZ;
				vrc_pkg::CAR_8K: next_st.drv.carrier_hz = vrc_pkg::CAR_8K_HZ;
				vrc_pkg::CAR_10K: next_st.drv.carrier_hz = vrc_pkg::CAR_10K_HZ;
				vrc_pkg::CAR_12K: next_st.drv.carrier_hz = vrc_pkg::CAR_12K_HZ;
				vrc_pkg::CAR_14K: next_st.drv.carrier_hz = vrc_pkg::CAR_14K_HZ;
			endcase
		end

		// -----------------------------------------------------------
		// Start and restart supervisor
		// -----------------------------------------------------------
		next_st.dc_lvl = dc_injection_level;
		tmr_done = st.tick && st.tmr == '0;
		if (st.tick && st.tmr != '0) begin
			next_st.tmr = st.tmr - 20'h00001;
		end
		start_req = terminal_control ? (st.sync2 && !st.sync3) : keypad_start;
		stop_req = terminal_control ? !st.sync2 : keypad_stop;
		auto_ok = terminal_control && st.sync2
			&& (start_mode == vrc_pkg::MODE_AUTO_RESTART
			|| start_mode == vrc_pkg::MODE_BRAKE_RESTART);
		inc = 1'b0;
		dec = 1'b0;
		if (st.tick) begin
			if (st.decay == DECAY_TICKS - 20'h00001) begin
				next_st.decay = '0;
				dec = (st.attempts != '0);
			end else begin
				next_st.decay = st.decay + 20'h00001;
			end
		end
		unique case (st.state)
			vrc_pkg::ST_PWRUP: begin
				if (tmr_done) begin
					if (terminal_control && st.sync2
						&& (start_mode == vrc_pkg::MODE_POWER_ON
						|| start_mode == vrc_pkg::MODE_AUTO_RESTART)) begin
						next_st.state = vrc_pkg::ST_RUN;
					end else begin
						next_st.state = vrc_pkg::ST_IDLE;
					end
				end
			end
			vrc_pkg::ST_IDLE: begin
				if (start_req) begin
					next_st.state = vrc_pkg::ST_RUN;
				end
			end
			vrc_pkg::ST_RUN: begin
				if (fault.valid) begin
					next_st.state = vrc_pkg::ST_IDLE;
					if (fault.kind == vrc_pkg::FLT_CONTROL
						|| fault.kind == vrc_pkg::FLT_SUPPLY_DIP) begin
						next_st.state = vrc_pkg::ST_IDLE;
					end else if (st.lowf_retry) begin
						next_st.state = vrc_pkg::ST_LOCK;
					end else if (auto_ok) begin
						if (st.attempts == vrc_pkg::MAX_ATTEMPTS) begin
							next_st.state = vrc_pkg::ST_LOCK;
						end else if (fault.kind == vrc_pkg::FLT_OUTPUT
							&& st.drv.output_frequency < vrc_pkg::LOWF_OUT) begin
							inc = 1'b1;
							next_st.lowf_retry = 1'b1;
							next_st.state = vrc_pkg::ST_DELAY;
							next_st.tmr = LOWF_TICKS - 20'h00001;
						end else if (start_mode
							== vrc_pkg::MODE_BRAKE_RESTART) begin
							inc = 1'b1;
							next_st.state = vrc_pkg::ST_BRAKE;
							next_st.tmr = BRAKE_TICKS - 20'h00001;
						end else begin
							inc = 1'b1;
							next_st.state = vrc_pkg::ST_RUN;
						end
					end
				end else if (stop_req) begin
					next_st.state = vrc_pkg::ST_IDLE;
				end
			end
			vrc_pkg::ST_BRAKE, vrc_pkg::ST_DELAY: begin
				if (tmr_done) begin
					next_st.state = auto_ok ? vrc_pkg::ST_RUN
						: vrc_pkg::ST_IDLE;
				end
			end
			vrc_pkg::ST_LOCK: next_st.state = vrc_pkg::ST_LOCK;
			default: next_st.state = vrc_pkg::ST_IDLE;
		endcase
		if (inc && !dec) begin
			next_st.attempts = st.attempts + 3'h1;
		end else if (dec && !inc) begin
			next_st.attempts = st.attempts - 3'h1;
		end
		if (manual_reset && !(fault.valid && st.state == vrc_pkg::ST_RUN)) begin
			next_st.attempts = '0;
			next_st.lowf_retry = 1'b0;
			if (st.state == vrc_pkg::ST_LOCK) begin
				next_st.state = vrc_pkg::ST_IDLE;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
			st.car_sel <= vrc_pkg::CARRIER_RST;
			st.tmr <= POWERUP_TICKS - 20'h00001;
		end else begin
			st <= next_st;
		end
	end

	assign drive = st.drv;
	assign carrier_rejected = st.car_rej;
	assign run_enable = (st.state == vrc_pkg::ST_RUN);
	assign dc_injection_active = (st.state == vrc_pkg::ST_BRAKE);
	assign dc_level_out = st.dc_lvl;
	assign restart_exhausted_lock = (st.state == vrc_pkg::ST_LOCK);
	assign restart_attempts = st.attempts;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_volt_at_base: assert property (
		$past(rst_n && cmd_freq >= cfg.base_freq)
		|-> drive.output_voltage == vrc_pkg::V_FULL)
		else $error("voltage not full above base");
	a_volt_ceiling: assert property (
		drive.output_voltage <= vrc_pkg::V_FULL)
		else $error("voltage above full");
	a_boost_zero_hz: assert property (
		$past(rst_n && cmd_freq == '0 && eff_boost <= vrc_pkg::V_FULL
		&& cfg.base_freq > 16'h0001 && (!run_enable || ~|set_point))
		|-> drive.output_voltage == $past(eff_boost))
		else $error("boost at zero hz wrong");
	a_slip_off: assert property (
		$past(rst_n && cfg.load_speed_correction == '0
		&& cmd_freq <= cfg.top_output_frequency_limit)
		|-> drive.output_frequency == $past(cmd_freq))
		else $error("frequency moved without slip");
	a_overload_flat: assert property (
		$past(rst_n) |-> drive.overload_speed_independent
		== $past(cfg.curve == vrc_pkg::CURVE_CT_FLAT))
		else $error("overload form wrong");
	a_carrier_legal: assert property (
		carrier_write && carrier_code >= vrc_pkg::CAR_CODES
		|=> $stable(st.car_sel) && carrier_rejected)
		else $error("illegal carrier taken");
	a_carrier_low: assert property (
		$past(!forced && st.car_sel == vrc_pkg::CAR_2K5
		&& st.drv.output_frequency <= vrc_pkg::VC_KNEE)
		|-> drive.carrier_hz == vrc_pkg::VC_FIXED_HZ)
		else $error("variable carrier low wrong");
	a_carrier_forced: assert property (
		$past(rst_n && forced) |-> drive.carrier_hz == vrc_pkg::CAR_14K_HZ
		&& !drive.carrier_menu_visible)
		else $error("carrier not forced");
	a_keypad_pwrup: assert property (
		st.state == vrc_pkg::ST_PWRUP && !terminal_control |=> !run_enable)
		else $error("power-up start under keypad");
	a_brake_hold: assert property (
		dc_injection_active && !tmr_done |=> dc_injection_active)
		else $error("brake ended early");
	a_no_ctrl_restart: assert property (
		run_enable && fault.valid && fault.kind == vrc_pkg::FLT_CONTROL
		|=> st.state == vrc_pkg::ST_IDLE)
		else $error("restart after control fault");
	a_attempt_bound: assert property (
		restart_attempts <= vrc_pkg::MAX_ATTEMPTS)
		else $error("too many attempts");
	a_lock_hold: assert property (
		restart_exhausted_lock && !manual_reset
		|=> restart_exhausted_lock && !run_enable)
		else $error("lockout left without reset");

	c_brake: cover property ($rose(dc_injection_active));
	c_lock: cover property ($rose(restart_exhausted_lock));
	c_delay: cover property (st.state == vrc_pkg::ST_DELAY);
	c_var_high: cover property (st.car_sel == vrc_pkg::CAR_2K5
		&& st.drv.output_frequency > vrc_pkg::VC_KNEE);

endmodule

`default_nettype wire

// *** test/vrc_motor_model.sv ***
/*
 * Motor behind the power stage: draws the load current while the drive
 * applies voltage. Assumes the drive outputs are registered on clk.
 */
`timescale 1ns/1ns
`default_nettype none

module vrc_motor_model (
	input  wire logic                clk,
	input  wire vrc_pkg::vrc_drive_s drive,
	input  wire logic [13:0]         load,
	output logic      [13:0]         motor_current
);
	// No voltage, no current
	always_ff @(posedge clk) begin
		motor_current <= (drive.output_voltage != 14'h0000) ? load : 14'h0000;
	end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
/*
 * Bench for vrc_core: profile, carrier and restart supervisor sequences.
 * Assumes shortened timer parameters and the motor model beside the core.
 */
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	logic                  clk, rst_n, cls, cwr, term, pin, kst, mrs, kstp;
	vrc_pkg::vrc_profile_s cfg;
	logic [4:0]            rating;
	logic [2:0]            code, att;
	logic [15:0]           cmd, setp;
	logic [13:0]           cur, ld;
	vrc_pkg::vrc_mode_e    mode;
	vrc_pkg::vrc_fault_s   fault;
	vrc_pkg::vrc_drive_s   drv;
	logic                  rej, run, dca, lock;
	logic [7:0]            dcl, dcin;
	int                    n_errors, tests_run, cycles;

	vrc_core #(
		.TICK_CYCLES  (17'h00004),
		.POWERUP_TICKS(20'h00003),
		.BRAKE_TICKS  (20'h00005),
		.LOWF_TICKS   (20'h00006),
		.DECAY_TICKS  (20'h000C8)
	) u_dut (
		.clk(clk), .rst_n(rst_n), .cfg(cfg), .rating_index(rating),
		.supply_class_high(cls), .carrier_code(code), .carrier_write(cwr),
		.cmd_freq(cmd), .set_point(setp), .motor_current(cur),
		.start_mode(mode), .terminal_control(term), .start_pin(pin),
		.keypad_start(kst), .keypad_stop(kstp), .fault(fault),
		.manual_reset(mrs), .dc_injection_level(dcin), .drive(drv),
		.carrier_rejected(rej), .run_enable(run), .dc_injection_active(dca),
		.dc_level_out(dcl), .restart_exhausted_lock(lock),
		.restart_attempts(att)
	);
	vrc_motor_model u_motor (.clk(clk), .drive(drv), .load(ld),
		.motor_current(cur));

	// ---------------------------------------------------------------
	// Bench helpers
	// ---------------------------------------------------------------
	task automatic close_out();
		if (n_errors == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] s,
		input logic [15:0] x);
		tests_run++;
		if (s !== x) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic wn(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic prof(input logic [15:0] f, input logic [13:0] b,
		input vrc_pkg::vrc_curve_e c, input logic [15:0] x);
		@(posedge clk);
		cmd <= f;
		cfg.fixed_low_speed_boost <= b;
		cfg.curve <= c;
		wn(4);
		chk("voltage", 16'(drv.output_voltage), x);
	endtask
	task automatic bst(input logic [4:0] r, input logic h,
		input logic [15:0] x);
		@(posedge clk);
		rating <= r;
		cls <= h;
		wn(4);
		chk("default boost", 16'(drv.output_voltage), x);
	endtask
	task automatic car(input logic [2:0] c, input logic [15:0] x);
		@(posedge clk);
		code <= c;
		cwr <= 1'b1;
		@(posedge clk);
		cwr <= 1'b0;
		wn(3);
		chk("carrier", drv.carrier_hz, x);
	endtask
	task automatic flt(input vrc_pkg::vrc_fault_e k);
		@(posedge clk);
		fault <= '{valid: 1'b1, kind: k};
		@(posedge clk);
		fault.valid <= 1'b0;
		wn(3);
	endtask
	task automatic go();
		@(posedge clk);
		mode <= vrc_pkg::MODE_NORMAL;
		pin <= 1'b0;
		wn(4);
		pin <= 1'b1;
		wn(6);
		mode <= vrc_pkg::MODE_AUTO_RESTART;
	endtask
	task automatic mr();
		@(posedge clk);
		mrs <= 1'b1;
		@(posedge clk);
		mrs <= 1'b0;
		wn(2);
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			n_errors++;
			close_out();
		end
	end

	// ---------------------------------------------------------------
	// Sequence
	// ---------------------------------------------------------------
	initial begin
		{rst_n, cls, cwr, kst, mrs, kstp, rating, code, setp} = '0;
		{dcin, ld} = {8'h5A, 14'h2710};
		{n_errors, tests_run, cycles} = '0;
		cfg = '0;
		cfg.base_freq = 16'h0258;
		cfg.top_output_frequency_limit = 16'h0FA0;
		cmd = 16'h012C;
		mode = vrc_pkg::MODE_POWER_ON;
		{term, pin} = 2'h3;
		fault = '0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		wn(30);
		chk("power-on run", 16'(run), 16'h0001);
		prof(16'h012C, 14'h0000, vrc_pkg::CURVE_CONST, 16'h1388);
		prof(16'h0384, 14'h0000, vrc_pkg::CURVE_CONST, 16'h2710);
		prof(16'h0096, 14'h03E8, vrc_pkg::CURVE_CONST, 16'h0BB8);
		prof(16'h012C, 14'h03E8, vrc_pkg::CURVE_CONST, 16'h1388);
		prof(16'h012C, 14'h0000, vrc_pkg::CURVE_VAR, 16'h09C4);
		prof(16'h0000, 14'h3FFF, vrc_pkg::CURVE_CONST, 16'h2710);
		chk("overload", 16'(drv.overload_speed_independent), 16'h0000);
		prof(16'h012C, 14'h0000, vrc_pkg::CURVE_CT_FLAT, 16'h1388);
		chk("overload", 16'(drv.overload_speed_independent), 16'h0001);
		setp <= 16'h01F4;
		cfg.accel_voltage_boost <= 14'h03E8;
		prof(16'h012C, 14'h0000, vrc_pkg::CURVE_CONST, 16'h1770);
		setp <= 16'h012C;
		prof(16'h012C, 14'h0000, vrc_pkg::CURVE_CONST, 16'h1388);
		cfg.load_speed_correction <= 14'h012C;
		wn(6);
		chk("slip freq", drv.output_frequency, 16'h013E);
		ld <= 14'h1388;
		wn(6);
		chk("slip half load", drv.output_frequency, 16'h0135);
		cfg.load_speed_correction <= 14'h0000;
		setp <= '0;
		cfg.use_default_boost <= 1'b1;
		prof(16'h0000, 14'h0000, vrc_pkg::CURVE_CONST, 16'h0212);
		bst(5'h09, 1'b0, 16'h00A0);
		bst(5'h0A, 1'b1, 16'h0078);
		cfg.use_default_boost <= 1'b0;
		cmd <= 16'h01C2;
		car(3'h1, 16'h1770);
		car(3'h2, 16'h1F40);
		car(3'h3, 16'h2710);
		car(3'h4, 16'h2EE0);
		car(3'h5, 16'h36B0);
		car(3'h0, 16'h0A8C);
		cmd <= 16'h00FA;
		wn(4);
		chk("carrier", drv.carrier_hz, 16'h05DC);
		code <= 3'h7;
		cwr <= 1'b1;
		@(posedge clk);
		cwr <= 1'b0;
		@(negedge clk);
		chk("rejected", 16'(rej), 16'h0001);
		wn(3);
		chk("rejected", 16'(rej), 16'h0000);
		chk("carrier", drv.carrier_hz, 16'h05DC);
		cfg.top_output_frequency_limit <= 16'h04B1;
		cfg.high_freq_option <= 1'b1;
		wn(4);
		chk("forced carrier", drv.carrier_hz, 16'h36B0);
		chk("menu", 16'(drv.carrier_menu_visible), 16'h0000);
		cfg.top_output_frequency_limit <= 16'h0FA0;
		cfg.high_freq_option <= 1'b0;
		mode <= vrc_pkg::MODE_AUTO_RESTART;
		repeat (5) flt(vrc_pkg::FLT_PROTECT);
		chk("auto restart", 16'(run), 16'h0001);
		chk("attempts", 16'(att), 16'h0005);
		flt(vrc_pkg::FLT_PROTECT);
		chk("lockout", 16'(lock), 16'h0001);
		chk("locked run", 16'(run), 16'h0000);
		mr();
		chk("lockout", 16'(lock), 16'h0000);
		chk("attempts", 16'(att), 16'h0000);
		go();
		chk("normal start", 16'(run), 16'h0001);
		flt(vrc_pkg::FLT_PROTECT);
		chk("attempts", 16'(att), 16'h0001);
		wn(820);
		chk("attempts decay", 16'(att), 16'h0000);
		flt(vrc_pkg::FLT_CONTROL);
		chk("control run", 16'(run), 16'h0000);
		go();
		flt(vrc_pkg::FLT_SUPPLY_DIP);
		chk("dip run", 16'(run), 16'h0000);
		cmd <= 16'h000A;
		go();
		flt(vrc_pkg::FLT_OUTPUT);
		chk("low-f wait", 16'(run), 16'h0000);
		wn(30);
		chk("low-f retry", 16'(run), 16'h0001);
		flt(vrc_pkg::FLT_PROTECT);
		chk("low-f lockout", 16'(lock), 16'h0001);
		mr();
		cmd <= 16'h012C;
		go();
		mode <= vrc_pkg::MODE_BRAKE_RESTART;
		flt(vrc_pkg::FLT_PROTECT);
		chk("dc active", 16'(dca), 16'h0001);
		chk("dc level", 16'(dcl), 16'h005A);
		wn(25);
		chk("brake restart", 16'({run, dca}), 16'h0002);
		dcin <= 8'hA5;
		wn(2);
		chk("dc level", 16'(dcl), 16'h00A5);
		flt(vrc_pkg::FLT_CONTROL);
		term <= 1'b0;
		mode <= vrc_pkg::MODE_AUTO_RESTART;
		kst <= 1'b1;
		@(posedge clk);
		kst <= 1'b0;
		wn(4);
		chk("keypad run", 16'(run), 16'h0001);
		flt(vrc_pkg::FLT_PROTECT);
		chk("keypad fault", 16'(run), 16'h0000);
		kst <= 1'b1;
		@(posedge clk);
		kst <= 1'b0;
		wn(4);
		chk("keypad rerun", 16'(run), 16'h0001);
		kstp <= 1'b1;
		wn(2);
		chk("keypad stop", 16'(run), 16'h0000);
		close_out();
	end
endmodule
`default_nettype wire
